//--- common/dct_pkg.sv
// constants shared by the dual counter/timer block
package dct_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_SHORT_CTRL  = 6'h00;
  localparam logic [5:0] IDX_SHARED_CTRL = 6'h01;
  localparam logic [5:0] IDX_LONG_CTRL   = 6'h02;
  localparam logic [5:0] IDX_SHORT_LOW   = 6'h04;
  localparam logic [5:0] IDX_SHORT_HIGH  = 6'h05;
  localparam logic [5:0] IDX_LONG_LOW    = 6'h06;
  localparam logic [5:0] IDX_LONG_HIGH   = 6'h07;
  localparam logic [5:0] IDX_LCAP_LOW    = 6'h08;
  localparam logic [5:0] IDX_LCAP_HIGH   = 6'h09;
  localparam logic [5:0] IDX_SCAP_LOW    = 6'h0a;

  // ----------------------------------------------------------------
  // short and long control register fields
  // ----------------------------------------------------------------
  localparam int B_RUN    = 7;
  localparam int B_MODE   = 6;
  localparam int B_TMO    = 5;
  localparam int B_CLK_HI = 4;
  localparam int B_CLK_LO = 3;
  localparam int B_CAP_IE = 2;
  localparam int B_TMO_IE = 1;
  localparam int B_ROUTE  = 0;

  // ----------------------------------------------------------------
  // shared control register fields
  // ----------------------------------------------------------------
  localparam int B_DEMOD    = 7;
  localparam int B_MARK_F   = 6;
  localparam int B_EDGE_FAL = 5;
  localparam int B_EDGE_RIS = 4;
  localparam int B_OMODE_HI = 3;
  localparam int B_OMODE_LO = 2;
  localparam int B_SINIT    = 1;
  localparam int B_LINIT    = 0;
  localparam int B_RISE_F   = 1;
  localparam int B_FALL_F   = 0;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  OM_FORCE0 = 2'h2;
  localparam logic [1:0]  OM_FORCE1 = 2'h3;
  localparam logic [15:0] LONG_WRAP = 16'hffff;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam int          PRE_W_DEF = 3;

  // long counter phases
  typedef enum logic [1:0] {LS_IDLE, LS_ARM, LS_COUNT} dct_long_state_e;

endpackage : dct_pkg

//--- rtl/dct_prescale.sv
// count-clock enable divider for one counter
`timescale 1ns/100ps
module dct_prescale
  import dct_pkg::*;
#(
  parameter int W = PRE_W_DEF
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // divide select: 0 /1, 1 /2, 2 /4, 3 /8
  input  wire logic [1:0] sel_i,
  // one-cycle count enable
  output logic            tick_o
);

  logic [W-1:0] cnt;
  logic [W-1:0] mask;

  // free running divider
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  // tick when the selected low bits are all ones
  always_comb
  begin
    mask   = W'((1 << sel_i) - 1);
    tick_o = ((cnt & mask) == mask);
  end

endmodule : dct_prescale

//--- rtl/dct_timer.sv
// dual counter/timer with demodulation capture and apb registers
`timescale 1ns/100ps

// Contract
// - short counter runs only while run bit 7 is set; clears at power-on
// - bit 6 picks modulo-N reload (0, default) or single pass (1)
// - bit 5 flags short time-out; write 1 clears, write 0 ignored
// - bits 4:3 pick short count clock: system clock /1, /2, /4, /8
// - bit 2 capture and bit 1 time-out interrupt enables; kept on recovery
// - bit 0 routes short counter output to its pin, else port data
// - disabled long counter in transmit outputs inverse of initial-value bit
// - output mode 10 or 11 forces long output low or high always
// - long enable loads high hold times 256 plus low; output takes initial
// - long zero in transmit toggles output, sets status, may interrupt
// - long counter in transmit stops in single pass, reloads hold in modulo-N
// - hold registers writable any time; used only at the next load
// - long initial count zero wraps to all ones without time-out
// - demodulation: first qualifying edge captures, reloads, starts counting
// - mode bit 0: later edges capture complemented count, reload all ones
// - each edge capture sets an edge flag and may interrupt
// - mode bit 1: edges after the first are ignored, no reload
// - mark mode: short time-out captures long count, may interrupt
// - mode bit written 0 then 1 re-arms one edge capture
// - demodulation zero wraps to all ones, sets status, may interrupt
module dct_timer
  import dct_pkg::*;
#(
  parameter int PRE_W = PRE_W_DEF
)
(
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  // stop-mode recovery, one-cycle pulse on this clock
  input  wire logic        STOP_RECOVER_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // pins and port data
  input  wire logic        CARRIER_I,
  input  wire logic        SHORT_PORT_I,
  input  wire logic        LONG_PORT_I,
  output logic             SHORT_PIN_O,
  output logic             LONG_PIN_O,
  // interrupt requests
  output logic             SHORT_IRQ_O,
  output logic             LONG_IRQ_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0]  idx;
  logic [7:0]  wd;
  logic        wr_en;
  logic [7:0]  rd_byte;
  logic        rd_ok;
  // short control
  logic        s_run;
  logic        s_single;
  logic        s_tmo;
  logic [1:0]  s_clk;
  logic        s_cap_ie;
  logic        s_tmo_ie;
  logic        s_route;
  // shared control
  logic        sh_demod;
  logic [1:0]  sh_edge;
  logic [1:0]  sh_omode;
  logic        sh_sinit;
  logic        sh_linit;
  logic        rise_f;
  logic        fall_f;
  logic        mark_f;
  // long control
  logic        l_run;
  logic        l_mode;
  logic        l_tmo;
  logic [1:0]  l_clk;
  logic        l_cap_ie;
  logic        l_tmo_ie;
  logic        l_route;
  logic        rearm;
  // holds and captures
  logic [7:0]  s_lo;
  logic [7:0]  s_hi;
  logic [15:0] l_hold;
  logic [15:0] l_cap;
  logic [7:0]  s_cap;
  // counters
  logic [7:0]  s_cnt;
  logic        s_out;
  logic [15:0] l_cnt;
  logic        l_out;
  logic        l_fresh;
  dct_long_state_e l_st;
  // events
  logic        s_tick;
  logic        l_tick;
  logic        s_start;
  logic        l_start;
  logic        s_timeout;
  logic        l_timeout;
  logic        l_zero;
  logic        cap_edge;
  logic        cap_mark;
  logic        long_val;
  // carrier edge detect
  logic        car_s1;
  logic        car_s2;
  logic        car_d;
  logic [1:0]  pend;

  // register write strobe for one index
  function automatic logic wr_hit(input logic [5:0] i);
    wr_hit = wr_en && (idx == i) && (PADDR_I[1:0] == 2'h0);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign idx   = PADDR_I[7:2];
  assign wd    = PWDATA_I[7:0];
  assign wr_en = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

  // read decode
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_byte = BYTE_RST;
    case (idx)
      IDX_SHORT_CTRL:  rd_byte = {s_run, s_single, s_tmo, s_clk, s_cap_ie, s_tmo_ie, s_route};
      IDX_SHARED_CTRL: rd_byte = sh_demod ?
                         {sh_demod, mark_f, sh_edge, sh_omode, rise_f, fall_f} :
                         {sh_demod, 1'b0, sh_edge, sh_omode, sh_sinit, sh_linit};
      IDX_LONG_CTRL:   rd_byte = {l_run, l_mode, l_tmo, l_clk, l_cap_ie, l_tmo_ie, l_route};
      IDX_SHORT_LOW:   rd_byte = s_lo;
      IDX_SHORT_HIGH:  rd_byte = s_hi;
      IDX_LONG_LOW:    rd_byte = l_hold[7:0];
      IDX_LONG_HIGH:   rd_byte = l_hold[15:8];
      IDX_LCAP_LOW:    rd_byte = l_cap[7:0];
      IDX_LCAP_HIGH:   rd_byte = l_cap[15:8];
      IDX_SCAP_LOW:    rd_byte = s_cap;
      default:         rd_ok   = 1'b0;
    endcase
    if (PADDR_I[1:0] != 2'h0)
      rd_ok = 1'b0;
  end

  // one wait state, answer registered
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end
    else if (PSEL_I && PENABLE_I && !PREADY_O)
    begin
      PREADY_O  <= 1'b1;
      PSLVERR_O <= ~rd_ok;
      PRDATA_O  <= PWRITE_I ? 32'h0 : {24'h0, rd_byte};
    end
    else
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // short control register
  // ----------------------------------------------------------------
  assign s_start = wr_hit(IDX_SHORT_CTRL) & wd[B_RUN] & ~s_run;

  // bits cleared by power-on and by stop-mode recovery
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s_run    <= 1'b0;
      s_single <= 1'b0;
      s_route  <= 1'b0;
    end
    else if (STOP_RECOVER_I)
    begin
      s_run    <= 1'b0;
      s_single <= 1'b0;
      s_route  <= 1'b0;
    end
    else if (wr_hit(IDX_SHORT_CTRL))
    begin
      s_run    <= wd[B_RUN];
      s_single <= wd[B_MODE];
      s_route  <= wd[B_ROUTE];
    end
    else if (s_timeout && s_single)
      s_run <= 1'b0;
  end

  // bits cleared by power-on only
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s_tmo    <= 1'b0;
      s_clk    <= 2'h0;
      s_cap_ie <= 1'b0;
      s_tmo_ie <= 1'b0;
    end
    else
    begin
      if (wr_hit(IDX_SHORT_CTRL))
      begin
        s_clk    <= wd[B_CLK_HI:B_CLK_LO];
        s_cap_ie <= wd[B_CAP_IE];
        s_tmo_ie <= wd[B_TMO_IE];
      end
      if (s_timeout)
        s_tmo <= 1'b1;
      else if (wr_hit(IDX_SHORT_CTRL) && wd[B_TMO])
        s_tmo <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // shared control register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sh_demod <= 1'b0;
      sh_edge  <= 2'h0;
      sh_omode <= 2'h0;
      sh_sinit <= 1'b0;
      sh_linit <= 1'b0;
    end
    else if (wr_hit(IDX_SHARED_CTRL))
    begin
      sh_demod <= wd[B_DEMOD];
      sh_edge  <= wd[B_EDGE_FAL:B_EDGE_RIS];
      sh_omode <= wd[B_OMODE_HI:B_OMODE_LO];
      if (!sh_demod)
      begin
        sh_sinit <= wd[B_SINIT];
        sh_linit <= wd[B_LINIT];
      end
    end
  end

  // edge and mark flags: hardware set beats software clear
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rise_f <= 1'b0;
      fall_f <= 1'b0;
      mark_f <= 1'b0;
    end
    else
    begin
      if (cap_edge && pend[1])
        rise_f <= 1'b1;
      else if (wr_hit(IDX_SHARED_CTRL) && sh_demod && wd[B_RISE_F])
        rise_f <= 1'b0;
      if (cap_edge && !pend[1])
        fall_f <= 1'b1;
      else if (wr_hit(IDX_SHARED_CTRL) && sh_demod && wd[B_FALL_F])
        fall_f <= 1'b0;
      if (cap_mark)
        mark_f <= 1'b1;
      else if (wr_hit(IDX_SHARED_CTRL) && sh_demod && wd[B_MARK_F])
        mark_f <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // long control register
  // ----------------------------------------------------------------
  assign l_start = wr_hit(IDX_LONG_CTRL) & wd[B_RUN] & ~l_run;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      l_run    <= 1'b0;
      l_mode   <= 1'b0;
      l_clk    <= 2'h0;
      l_cap_ie <= 1'b0;
      l_tmo_ie <= 1'b0;
      l_route  <= 1'b0;
    end
    else if (wr_hit(IDX_LONG_CTRL))
    begin
      l_run    <= wd[B_RUN];
      l_mode   <= wd[B_MODE];
      l_clk    <= wd[B_CLK_HI:B_CLK_LO];
      l_cap_ie <= wd[B_CAP_IE];
      l_tmo_ie <= wd[B_TMO_IE];
      l_route  <= wd[B_ROUTE];
    end
    else if (l_timeout && !sh_demod && l_mode)
      l_run <= 1'b0;
  end

  // long status flag and edge re-arm
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      l_tmo <= 1'b0;
      rearm <= 1'b0;
    end
    else
    begin
      if (l_timeout)
        l_tmo <= 1'b1;
      else if (wr_hit(IDX_LONG_CTRL) && wd[B_TMO])
        l_tmo <= 1'b0;
      if (wr_hit(IDX_LONG_CTRL) && wd[B_MODE] && !l_mode)
        rearm <= 1'b1;
      else if (cap_edge)
        rearm <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // hold registers, sampled only at load time
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s_lo   <= BYTE_RST;
      s_hi   <= BYTE_RST;
      l_hold <= WORD_RST;
    end
    else
    begin
      if (wr_hit(IDX_SHORT_LOW))
        s_lo <= wd;
      if (wr_hit(IDX_SHORT_HIGH))
        s_hi <= wd;
      if (wr_hit(IDX_LONG_LOW))
        l_hold[7:0] <= wd;
      if (wr_hit(IDX_LONG_HIGH))
        l_hold[15:8] <= wd;
    end
  end

  // ----------------------------------------------------------------
  // count clock dividers
  // ----------------------------------------------------------------
  dct_prescale #(.W(PRE_W)) u_short_pre
  (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .sel_i   (s_clk),
    .tick_o  (s_tick)
  );

  dct_prescale #(.W(PRE_W)) u_long_pre
  (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .sel_i   (l_clk),
    .tick_o  (l_tick)
  );

  // ----------------------------------------------------------------
  // short counter
  // ----------------------------------------------------------------
  assign s_timeout = s_run & s_tick & (s_cnt == 8'h00) & ~s_start;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s_cnt <= BYTE_RST;
      s_out <= 1'b0;
    end
    else if (s_start)
    begin
      s_out <= sh_sinit;
      s_cnt <= sh_sinit ? s_hi : s_lo;
    end
    else if (s_run && s_tick)
    begin
      if (s_cnt == 8'h00)
      begin
        s_out <= ~s_out;
        s_cnt <= s_out ? s_lo : s_hi;
      end
      else
        s_cnt <= s_cnt - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // carrier edge detector
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      car_s1 <= 1'b0;
      car_s2 <= 1'b0;
      car_d  <= 1'b0;
    end
    else
    begin
      car_s1 <= CARRIER_I;
      car_s2 <= car_s1;
      car_d  <= car_s2;
    end
  end

  // pending edge kind, consumed once per long count period
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      pend <= 2'h0;
    else if (l_tick && pend[0])
      pend <= 2'h0;
    else if (sh_demod && pend == 2'h0)
    begin
      if (sh_edge[0] && car_s2 && !car_d)
        pend <= 2'h3;
      else if (sh_edge[1] && !car_s2 && car_d)
        pend <= 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // long counter
  // ----------------------------------------------------------------
  assign l_zero    = (l_cnt == 16'h0000) & ~l_fresh;
  assign cap_edge  = sh_demod & l_run & l_tick & pend[0] &
                     ((l_st == LS_ARM) | ~l_mode | rearm);
  assign cap_mark  = sh_demod & l_mode & (l_st == LS_COUNT) & s_timeout;
  assign l_timeout = l_run & (l_st == LS_COUNT) & l_tick & l_zero & ~cap_edge;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      l_st    <= LS_IDLE;
      l_cnt   <= WORD_RST;
      l_out   <= 1'b0;
      l_fresh <= 1'b0;
      l_cap   <= WORD_RST;
      s_cap   <= BYTE_RST;
    end
    else
    begin
      case (l_st)
        LS_IDLE:
          if (l_start)
          begin
            l_out   <= sh_linit;
            l_fresh <= 1'b1;
            l_cnt   <= l_hold;
            l_st    <= sh_demod ? LS_ARM : LS_COUNT;
          end
        LS_ARM:
          if (!l_run)
            l_st <= LS_IDLE;
          else if (cap_edge)
          begin
            l_cap   <= ~l_cnt;
            s_cap   <= s_cnt;
            l_cnt   <= l_hold;
            l_fresh <= 1'b1;
            l_st    <= LS_COUNT;
          end
        LS_COUNT:
          if (!l_run)
            l_st <= LS_IDLE;
          else if (cap_edge)
          begin
            l_cap   <= ~l_cnt;
            s_cap   <= s_cnt;
            l_cnt   <= LONG_WRAP;
            l_fresh <= 1'b1;
          end
          else
          begin
            if (cap_mark)
              l_cap <= l_cnt;
            if (l_tick)
            begin
              l_fresh <= 1'b0;
              if (l_zero && sh_demod)
                l_cnt <= LONG_WRAP;
              else if (l_zero)
              begin
                l_out   <= ~l_out;
                l_cnt   <= l_hold;
                l_fresh <= 1'b1;
              end
              else
                l_cnt <= l_cnt - 16'h0001;
            end
          end
        default:
          l_st <= LS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins and interrupt requests
  // ----------------------------------------------------------------
  always_comb
  begin
    if (sh_omode == OM_FORCE0)
      long_val = 1'b0;
    else if (sh_omode == OM_FORCE1)
      long_val = 1'b1;
    else if (l_st == LS_IDLE && !sh_demod)
      long_val = ~sh_linit;
    else
      long_val = l_out;
  end

  // registered pin drive and requests
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      SHORT_PIN_O <= 1'b0;
      LONG_PIN_O  <= 1'b0;
      SHORT_IRQ_O <= 1'b0;
      LONG_IRQ_O  <= 1'b0;
    end
    else
    begin
      SHORT_PIN_O <= s_route ? s_out : SHORT_PORT_I;
      LONG_PIN_O  <= l_route ? long_val : LONG_PORT_I;
      SHORT_IRQ_O <= (s_tmo & s_tmo_ie) |
                     ((rise_f | fall_f) & s_cap_ie);
      LONG_IRQ_O  <= (l_tmo & l_tmo_ie) |
                     ((rise_f | fall_f | mark_f) & l_cap_ie);
    end
  end

endmodule : dct_timer

//--- sim/dct_carrier_model.sv
// carrier pin model: square bursts on request
`timescale 1ns/100ps
module dct_carrier_model
#(
  parameter int HALF = 20
)
(
  // clock and burst request
  input  wire logic clk_i,
  input  wire logic burst_i,
  // carrier pin
  output logic      carrier_o
);
  int c;
  // toggle each half period in a burst, idle low
  always @(posedge clk_i)
    if (!burst_i)
    begin
      c         <= 0;
      carrier_o <= 1'b0;
    end
    else if (c == HALF - 1)
    begin
      c         <= 0;
      carrier_o <= ~carrier_o;
    end
    else
      c <= c + 1;
endmodule : dct_carrier_model

//--- sim/dct_timer_chk.sv
// port checker for the counter/timer
`timescale 1ns/100ps
module dct_timer_chk
  import dct_pkg::*;
(
  // clock, reset, recovery
  input wire logic        SYS_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        STOP_RECOVER_I,
  // apb
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // pins and requests
  input wire logic        CARRIER_I,
  input wire logic        SHORT_PORT_I,
  input wire logic        LONG_PORT_I,
  input wire logic        SHORT_PIN_O,
  input wire logic        LONG_PIN_O,
  input wire logic        SHORT_IRQ_O,
  input wire logic        LONG_IRQ_O
);
  logic       wr, srt, lrt;
  logic [5:0] ix;
  logic [1:0] sie, lie, om;
  // ----------------
  // mirrored control
  // ----------------
  assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
  assign ix = PADDR_I[7:2];
  // short control, recovery clears route only
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
      {srt, sie} <= 3'h0;
    else
    begin
      if (wr && ix == IDX_SHORT_CTRL)
        {srt, sie} <= {PWDATA_I[0], PWDATA_I[2:1]};
      if (STOP_RECOVER_I)
        srt <= 1'b0;
    end
  // long control and output mode
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
      {lrt, lie, om} <= 5'h00;
    else if (wr && ix == IDX_LONG_CTRL)
      {lrt, lie} <= {PWDATA_I[0], PWDATA_I[2:1]};
    else if (wr && ix == IDX_SHARED_CTRL)
      om <= PWDATA_I[3:2];
  default clocking dck @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than a cycle");
  chk_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("ready late");
  chk_err_decode: assert property (PREADY_O |-> PSLVERR_O ==
    (PADDR_I[1:0] != 2'h0 || ix == 6'h03 || ix > IDX_SCAP_LOW))
    else $error("bad error flag");
  chk_rdata_top: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
    else $error("read data top bits set");
  chk_short_port: assert property (RST_N_I && !srt |=> SHORT_PIN_O == $past(SHORT_PORT_I))
    else $error("short pin not port data");
  chk_force_low: assert property (lrt && om == OM_FORCE0 |=> !LONG_PIN_O)
    else $error("long pin not forced low");
  chk_force_high: assert property (lrt && om == OM_FORCE1 |=> LONG_PIN_O)
    else $error("long pin not forced high");
  chk_short_mask: assert property (sie == 2'h0 |=> !SHORT_IRQ_O)
    else $error("short request unmasked");
  chk_long_mask: assert property (lie == 2'h0 |=> !LONG_IRQ_O)
    else $error("long request unmasked");
  // main scenarios seen
  cover property (SHORT_IRQ_O);
  cover property (LONG_IRQ_O);
  cover property (PREADY_O && PSLVERR_O);
endmodule : dct_timer_chk
bind dct_timer dct_timer_chk dct_timer_chk_inst (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
  .STOP_RECOVER_I(STOP_RECOVER_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CARRIER_I(CARRIER_I),
  .SHORT_PORT_I(SHORT_PORT_I), .LONG_PORT_I(LONG_PORT_I), .SHORT_PIN_O(SHORT_PIN_O),
  .LONG_PIN_O(LONG_PIN_O), .SHORT_IRQ_O(SHORT_IRQ_O), .LONG_IRQ_O(LONG_IRQ_O));

//--- sim/dct_timer_test.sv
// self-checking bench for the counter/timer
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
$display("unexpected at %0t: %h not %h", $time, a, b); end end
module dct_timer_test
  import dct_pkg::*;
;
  logic        clk, rst_n, rec, psel, pen, pwr, car, burst;
  logic        sp = 1'b0, lp = 1'b0;
  logic        pready, perr, sirq, lirq, spin, lpin, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0]  tv [4] = '{9'h001, 9'h008, 9'h10d, 9'h100};
  int          mismatches, cmp_count, n, s;
  dct_timer dct_timer_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .STOP_RECOVER_I(rec),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .CARRIER_I(car),
    .SHORT_PORT_I(sp), .LONG_PORT_I(lp), .SHORT_PIN_O(spin), .LONG_PIN_O(lpin),
    .SHORT_IRQ_O(sirq), .LONG_IRQ_O(lirq));
  dct_carrier_model dct_carrier_model_inst (.clk_i(clk), .burst_i(burst), .carrier_o(car));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // changing port data
  always @(posedge clk)
    {sp, lp} <= {sp, lp} + 2'h1;
  // verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // timeout
  task automatic fail();
    mismatches++;
    $display("unexpected at %0t: timeout", $time);
    wrap_up();
  endtask : fail
  // one apb transfer, answer in r and e
  task automatic ap(input logic w, input logic [5:0] ix, input logic [7:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= {ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    repeat (20)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (pready !== 1'b1)
      fail();
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : ap
  // cycles until a request, in n
  task automatic wirq(input logic l);
    n = 0;
    while ((l ? lirq : sirq) !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 2000)
        fail();
    end
  endtask : wirq
  // main sequence
  initial
  begin
    {rst_n, rec, psel, pen, pwr, burst} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (s = 0; s < 11; s++)
    begin
      ap(1'b0, s[5:0], 8'h00);
      `CHK({e, r}, {s == 3, 32'h0})
    end
    ap(1'b1, IDX_SHORT_LOW, 8'ha5);
    ap(1'b0, IDX_SHORT_LOW, 8'h00);
    `CHK(r, 32'ha5)
    ap(1'b1, IDX_LCAP_LOW, 8'h5a);
    ap(1'b0, IDX_LCAP_LOW, 8'h00);
    `CHK(r, 32'h0)
    ap(1'b1, IDX_SHORT_CTRL, 8'h07);
    @(posedge clk) rec <= 1'b1;
    @(posedge clk) rec <= 1'b0;
    ap(1'b0, IDX_SHORT_CTRL, 8'h00);
    `CHK(r, 32'h06)
    $display("register test done");
    ap(1'b1, IDX_SHORT_LOW, 8'h07);
    for (s = 0; s < 4; s++)
    begin
      ap(1'b1, IDX_SHORT_CTRL, 8'hc2 | 8'(s << 3));
      wirq(1'b0);
      `CHK(n inside {[6 << s : (9 << s) + 8]}, 1'b1)
      ap(1'b0, IDX_SHORT_CTRL, 8'h00);
      `CHK(r, 32'h62 | 32'(s << 3))
      ap(1'b1, IDX_SHORT_CTRL, 8'h42 | 8'(s << 3));
      ap(1'b0, IDX_SHORT_CTRL, 8'h00);
      `CHK(r, 32'h62 | 32'(s << 3))
      ap(1'b1, IDX_SHORT_CTRL, 8'h20);
      ap(1'b0, IDX_SHORT_CTRL, 8'h00);
      `CHK(r, 32'h0)
    end
    $display("short test done");
    ap(1'b1, IDX_LONG_CTRL, 8'h01);
    for (s = 0; s < 4; s++)
    begin
      ap(1'b1, IDX_SHARED_CTRL, tv[s][7:0]);
      repeat (3) @(posedge clk);
      `CHK(lpin, tv[s][8])
    end
    ap(1'b1, IDX_LONG_HIGH, 8'h01);
    ap(1'b1, IDX_LONG_LOW, 8'h02);
    ap(1'b1, IDX_LONG_CTRL, 8'hc3);
    repeat (2) @(posedge clk);
    `CHK(lpin, 1'b0)
    wirq(1'b1);
    `CHK(n inside {[250 : 266]}, 1'b1)
    repeat (2) @(posedge clk);
    `CHK(lpin, 1'b1)
    ap(1'b0, IDX_LONG_CTRL, 8'h00);
    `CHK(r, 32'h63)
    ap(1'b1, IDX_LONG_CTRL, 8'ha3);
    repeat (2) @(posedge clk);
    wirq(1'b1);
    ap(1'b1, IDX_LONG_CTRL, 8'ha3);
    repeat (2) @(posedge clk);
    wirq(1'b1);
    `CHK(n inside {[250 : 266]}, 1'b1)
    ap(1'b1, IDX_LONG_CTRL, 8'h20);
    $display("transmit test done");
    ap(1'b1, IDX_LONG_HIGH, 8'hff);
    ap(1'b1, IDX_LONG_LOW, 8'hff);
    ap(1'b1, IDX_SHARED_CTRL, 8'h90);
    ap(1'b1, IDX_LONG_CTRL, 8'h84);
    burst <= 1'b1;
    wirq(1'b1);
    ap(1'b0, IDX_SHARED_CTRL, 8'h00);
    `CHK(r, 32'h92)
    ap(1'b1, IDX_SHARED_CTRL, 8'h92);
    repeat (2) @(posedge clk);
    wirq(1'b1);
    ap(1'b0, IDX_LCAP_LOW, 8'h00);
    n = int'(r);
    ap(1'b0, IDX_LCAP_HIGH, 8'h00);
    `CHK(r, 32'h0)
    `CHK(n inside {[36 : 44]}, 1'b1)
    burst <= 1'b0;
    $display("demodulation test done");
    wrap_up();
  end
endmodule : dct_timer_test
